// ---- hw/cpg_pkg.sv ----
// Purpose: Shared constants for the charger protection and gate control block.
// Assumes: 40 MHz system clock.
// Notes:   Analog thresholds are resolved by external comparators; timing, flag indices and state types live here.
package cpg_pkg;
    localparam int CLK_MHZ         = 40;
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int DEAD_TIME_PS    = 30000;
    localparam int RECHARGE_PS     = 80000;
    localparam int BBM_US          = 10;
    localparam int ADAPTER_QUAL_MS = 700;
    // A least time rounds up, a longest time rounds down.
    localparam int DEAD_CYC        = (DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECHARGE_CYC    = (RECHARGE_PS / CLK_PERIOD_PS) < 1 ? 1 : (RECHARGE_PS / CLK_PERIOD_PS);
    localparam int BBM_CYC         = BBM_US * CLK_MHZ;
    localparam int QUAL_CYC        = ADAPTER_QUAL_MS * 1000 * CLK_MHZ;
    localparam int CNT_W           = 32;
    localparam int NUM_FLAGS       = 13;
    // Flag indices into the synchronised comparator vector.
    localparam int F_PWM           = 0;
    localparam int F_SYNC_LO       = 1;
    localparam int F_SYNC_HI       = 2;
    localparam int F_BOOT_LOW      = 3;
    localparam int F_OVP           = 4;
    localparam int F_SUPPLY_OK     = 5;
    localparam int F_DET_LO        = 6;
    localparam int F_DET_HI        = 7;
    localparam int F_ADP_LOW       = 8;
    localparam int F_BAT_OV_HI     = 9;
    localparam int F_BAT_OV_LO     = 10;
    localparam int F_BATTERY_SHORT_FLAG     = 11;
    localparam int F_LEARN         = 12;
    typedef enum logic [2:0] {CPG_OFF, CPG_HIGH, CPG_DEAD_LO, CPG_LOW, CPG_PULSE, CPG_IDLE, CPG_DEAD_HI} cpg_gate_t;
    typedef enum logic [1:0] {CPG_SEL_BAT, CPG_SEL_GAP, CPG_SEL_ADP} cpg_sel_t;
endpackage : cpg_pkg

// ---- hw/cpg_top.sv ----
// What this block does
// R1 - Diode emulation below sync threshold, else synchronous.
// R2 - Sync decision: fall 13 mV, rise plus 8.
// R3 - Synchronous: complementary drives with 30 ns dead.
// R4 - Non-synchronous: one 80 ns low pulse after dead.
// R5 - Bootstrap low: only recharge pulse, no switching.
// R6 - Overvoltage: stop charge, adapter off, battery on.
// R7 - Overvoltage not latched, resumes automatically.
// R8 - Supply low: bias and switch drives inactive.
// R9 - Adapter node low: stay on battery.
// R10 - Battery over 104% stop, until below 102%.
// R11 - Battery short flag, charge target one eighth.
// R12 - Learn plus short: switch to adapter.
// R13 - Learn, battery recovers: back to battery.
// R14 - Over 145% current: high side off.
// R15 - Thermal shutdown above 155, release below 135.
// R16 - Adapter good low after 2.4 V and 700 ms.
// R17 - Current monitor grounded until supply and detect.
// R18 - Learn with adapter: battery on, no charge.
// R19 - Source change: both switches off 10 us.
// R20 - Comparators synchronised; delays counted from clock.
// Purpose: Gate sequencing, power selector and fault supervision of a charger.
// Assumes: Comparator flags are asynchronous levels; hysteresis pairs arrive as two flags.
// Notes:   Switch drive outputs are active high meaning switch on.
`timescale 1ns/1ps
module cpg_top #(
    parameter int QUAL_CYCLES = cpg_pkg::QUAL_CYC                  // Adapter qualification count.
) (
    input  wire logic clk_i,                                       // 40 MHz clock.
    input  wire logic reset_n_i,                                   // Async reset, active low.
    input  wire logic pwm_high_i,                                  // PWM request for high side.
    input  wire logic sync_below_13mv_i,                           // Sense below 13 mV.
    input  wire logic sync_above_21mv_i,                           // Sense above 13 mV plus 8 mV.
    input  wire logic boot_below_4v_i,                             // Bootstrap to phase under 4 V.
    input  wire logic ovp_above_i,                                 // Overvoltage set above 3.1 V.
    input  wire logic supply_above_5v_i,                           // Supply above 5 V.
    input  wire logic detect_above_0v6_i,                          // Adapter detect above 0.6 V.
    input  wire logic detect_above_2v4_i,                          // Adapter detect above 2.4 V.
    input  wire logic adapter_node_below_3v_i,                     // Adapter node below 3 V.
    input  wire logic bat_above_104_i,                             // Battery above 104 percent.
    input  wire logic bat_below_102_i,                             // Battery below 102 percent.
    input  wire logic battery_short_flag_i,                                 // Battery below short threshold.
    input  wire logic learn_i,                                     // Learn cycle request.
    input  wire logic overcurrent_i,                               // Charge current above 145 percent.
    input  wire logic thermal_hot_i,                               // Junction above 155 C.
    input  wire logic thermal_cool_i,                              // Junction below 135 C.
    output logic      high_side_gate_drive_o,                      // High side driver on.
    output logic      low_side_gate_drive_o,                       // Low side driver on.
    output logic      adapter_switch_drive_o,                      // Adapter switch on.
    output logic      battery_switch_drive_o,                      // Battery switch on.
    output logic      adapter_good_out_oe_o,                       // Pulls open-drain status low.
    output logic      adapter_good_out_o,                          // Status pin output level.
    output logic      input_current_monitor_en_o,                  // Current monitor active.
    output logic      gate_bias_regulator_en_o,                    // Bias regulator enabled.
    output logic      charge_enable_o,                             // Charging allowed.
    output logic      precharge_eighth_o,                          // Charge target cut to one eighth.
    output logic      battery_short_flag_o,                        // Battery short status.
    output logic      thermal_shutdown_flag_o,                     // Thermal shutdown status.
    output logic      input_overvoltage_flag_o,                    // Input overvoltage status.
    output logic      continuous_mode_o                            // Synchronous mode active.
);
    // ==================================================================
    // Input synchronisers
    // ==================================================================
    localparam int N = cpg_pkg::NUM_FLAGS;
    logic [N-1:0] raw;
    logic [N-1:0] meta_r;
    logic [N-1:0] flag_r;
    assign raw = {learn_i, battery_short_flag_i, bat_below_102_i, bat_above_104_i, adapter_node_below_3v_i,
                  detect_above_2v4_i, detect_above_0v6_i, supply_above_5v_i, ovp_above_i,
                  boot_below_4v_i, sync_above_21mv_i, sync_below_13mv_i, pwm_high_i};
    logic       oc_meta_r, oc_r, hot_meta_r, hot_r, cool_meta_r, cool_r;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    meta_r[g] <= 1'b0;
                    flag_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= raw[g];                           // [R20]
                    flag_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oc_meta_r   <= 1'b0;
            oc_r        <= 1'b0;
            hot_meta_r  <= 1'b0;
            hot_r       <= 1'b0;
            cool_meta_r <= 1'b0;
            cool_r      <= 1'b0;
        end else begin
            oc_meta_r   <= overcurrent_i;                          // [R20]
            oc_r        <= oc_meta_r;
            hot_meta_r  <= thermal_hot_i;
            hot_r       <= hot_meta_r;
            cool_meta_r <= thermal_cool_i;
            cool_r      <= cool_meta_r;
        end
    end

    logic supply_ok;
    assign supply_ok = flag_r[cpg_pkg::F_SUPPLY_OK];

    // ==================================================================
    // Hysteretic supervisors
    // ==================================================================
    logic sync_r, bat_ov_r, thermal_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_r <= 1'b0;
        end else if (flag_r[cpg_pkg::F_SYNC_LO]) begin
            sync_r <= 1'b0;                                        // [R1] [R2]
        end else if (flag_r[cpg_pkg::F_SYNC_HI]) begin
            sync_r <= 1'b1;                                        // [R2]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bat_ov_r <= 1'b0;
        end else if (flag_r[cpg_pkg::F_BAT_OV_HI]) begin
            bat_ov_r <= 1'b1;                                      // [R10]
        end else if (flag_r[cpg_pkg::F_BAT_OV_LO]) begin
            bat_ov_r <= 1'b0;                                      // [R10]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            thermal_r <= 1'b0;
        end else if (hot_r) begin
            thermal_r <= 1'b1;                                     // [R15]
        end else if (cool_r) begin
            thermal_r <= 1'b0;                                     // [R15]
        end
    end

    // ==================================================================
    // Adapter qualification
    // ==================================================================
    logic [cpg_pkg::CNT_W-1:0] qual_cnt_r;
    logic                      adp_good_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            qual_cnt_r <= '0;
            adp_good_r <= 1'b0;
        end else if (!flag_r[cpg_pkg::F_DET_HI] || !supply_ok) begin
            qual_cnt_r <= '0;
            adp_good_r <= 1'b0;
        end else if (qual_cnt_r < cpg_pkg::CNT_W'(QUAL_CYCLES - 1)) begin
            qual_cnt_r <= qual_cnt_r + 1'b1;                       // [R16] [R20]
        end else begin
            adp_good_r <= 1'b1;                                    // [R16]
        end
    end

    // ==================================================================
    // System power selector
    // ==================================================================
    logic want_adp;
    logic learn_hold;
    // Learn overrides to battery unless the battery is depleted.
    assign learn_hold = flag_r[cpg_pkg::F_LEARN] && !flag_r[cpg_pkg::F_BATTERY_SHORT_FLAG];   // [R12] [R13] [R18]
    assign want_adp   = adp_good_r && !flag_r[cpg_pkg::F_OVP] && !learn_hold
                        && !flag_r[cpg_pkg::F_ADP_LOW];                                // [R6] [R7] [R9]

    cpg_pkg::cpg_sel_t         sel_r;
    logic                      sel_tgt_r;
    logic [cpg_pkg::CNT_W-1:0] bbm_cnt_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_r     <= cpg_pkg::CPG_SEL_BAT;
            sel_tgt_r <= 1'b0;
            bbm_cnt_r <= '0;
        end else begin
            unique case (sel_r)
                cpg_pkg::CPG_SEL_BAT: if (want_adp) begin
                    sel_r     <= cpg_pkg::CPG_SEL_GAP;             // [R19]
                    sel_tgt_r <= 1'b1;
                    bbm_cnt_r <= '0;
                end
                cpg_pkg::CPG_SEL_ADP: if (!want_adp) begin
                    sel_r     <= cpg_pkg::CPG_SEL_GAP;             // [R19]
                    sel_tgt_r <= 1'b0;
                    bbm_cnt_r <= '0;
                end
                cpg_pkg::CPG_SEL_GAP: begin
                    if (bbm_cnt_r >= cpg_pkg::CNT_W'(cpg_pkg::BBM_CYC - 1)) begin
                        sel_r <= sel_tgt_r ? cpg_pkg::CPG_SEL_ADP : cpg_pkg::CPG_SEL_BAT;
                    end else begin
                        bbm_cnt_r <= bbm_cnt_r + 1'b1;             // [R19] [R20]
                    end
                end
                default: sel_r <= cpg_pkg::CPG_SEL_BAT;
            endcase
        end
    end

    // ==================================================================
    // Charge permission and status
    // ==================================================================
    logic charge_ok;
    assign charge_ok = supply_ok && sel_r == cpg_pkg::CPG_SEL_ADP && !flag_r[cpg_pkg::F_OVP]
                       && !thermal_r && !flag_r[cpg_pkg::F_LEARN];                     // [R6] [R15] [R18]

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            adapter_switch_drive_o     <= 1'b0;
            battery_switch_drive_o     <= 1'b0;
            adapter_good_out_oe_o      <= 1'b0;
            adapter_good_out_o         <= 1'b0;
            input_current_monitor_en_o <= 1'b0;
            gate_bias_regulator_en_o   <= 1'b0;
            charge_enable_o            <= 1'b0;
            precharge_eighth_o         <= 1'b0;
            battery_short_flag_o       <= 1'b0;
            thermal_shutdown_flag_o    <= 1'b0;
            input_overvoltage_flag_o   <= 1'b0;
            continuous_mode_o          <= 1'b0;
        end else begin
            // Supply low keeps switch drive bias off, so both switches float off.
            adapter_switch_drive_o     <= supply_ok && sel_r == cpg_pkg::CPG_SEL_ADP && want_adp; // [R6] [R8] [R19]
            battery_switch_drive_o     <= supply_ok && sel_r == cpg_pkg::CPG_SEL_BAT;  // [R6] [R8] [R19]
            adapter_good_out_oe_o      <= adp_good_r;                                  // [R16]
            adapter_good_out_o         <= 1'b0;
            input_current_monitor_en_o <= supply_ok && flag_r[cpg_pkg::F_DET_LO];      // [R17]
            gate_bias_regulator_en_o   <= supply_ok;                                   // [R8]
            charge_enable_o            <= charge_ok;
            precharge_eighth_o         <= flag_r[cpg_pkg::F_BATTERY_SHORT_FLAG];                // [R11]
            battery_short_flag_o       <= flag_r[cpg_pkg::F_BATTERY_SHORT_FLAG];                // [R11]
            thermal_shutdown_flag_o    <= thermal_r;
            input_overvoltage_flag_o   <= flag_r[cpg_pkg::F_OVP];
            continuous_mode_o          <= sync_r;
        end
    end

    // ==================================================================
    // Gate drive sequencer
    // ==================================================================
    logic run, hs_allow;
    assign run      = charge_enable_o && supply_ok && !bat_ov_r;                       // [R10] [R15]
    assign hs_allow = run && flag_r[cpg_pkg::F_PWM] && !oc_r && !flag_r[cpg_pkg::F_BOOT_LOW]; // [R5] [R14]

    cpg_pkg::cpg_gate_t        gst_r;
    logic [cpg_pkg::CNT_W-1:0] gcnt_r;
    logic                      boot_pulse_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gst_r        <= cpg_pkg::CPG_OFF;
            gcnt_r       <= '0;
            boot_pulse_r <= 1'b0;
        end else begin
            gcnt_r <= gcnt_r + 1'b1;
            unique case (gst_r)
                cpg_pkg::CPG_OFF, cpg_pkg::CPG_IDLE: begin
                    if (hs_allow) begin
                        gst_r <= cpg_pkg::CPG_HIGH;
                    end else if (run && flag_r[cpg_pkg::F_BOOT_LOW] && !boot_pulse_r) begin
                        gst_r        <= cpg_pkg::CPG_PULSE;        // [R5]
                        boot_pulse_r <= 1'b1;
                        gcnt_r       <= '0;
                    end else if (run && sync_r && gst_r == cpg_pkg::CPG_OFF && !flag_r[cpg_pkg::F_BOOT_LOW]) begin
                        gst_r <= cpg_pkg::CPG_LOW;
                    end
                    if (!flag_r[cpg_pkg::F_BOOT_LOW]) begin
                        boot_pulse_r <= 1'b0;
                    end
                end
                cpg_pkg::CPG_HIGH: if (!hs_allow) begin
                    gst_r  <= cpg_pkg::CPG_DEAD_LO;                // [R3] [R14]
                    gcnt_r <= '0;
                end
                cpg_pkg::CPG_DEAD_LO: if (gcnt_r >= cpg_pkg::CNT_W'(cpg_pkg::DEAD_CYC - 1)) begin
                    gcnt_r       <= '0;
                    boot_pulse_r <= flag_r[cpg_pkg::F_BOOT_LOW];
                    if (!run) gst_r <= cpg_pkg::CPG_OFF;
                    else gst_r <= (sync_r && !flag_r[cpg_pkg::F_BOOT_LOW]) ? cpg_pkg::CPG_LOW
                                                                           : cpg_pkg::CPG_PULSE; // [R1] [R3] [R4] [R5]
                end
                cpg_pkg::CPG_LOW: if (hs_allow || !run || !sync_r || flag_r[cpg_pkg::F_BOOT_LOW]) begin // [R5]
                    gst_r  <= cpg_pkg::CPG_DEAD_HI;                // [R3]
                    gcnt_r <= '0;
                end
                cpg_pkg::CPG_PULSE: if (gcnt_r >= cpg_pkg::CNT_W'(cpg_pkg::RECHARGE_CYC - 1)) begin
                    gst_r <= cpg_pkg::CPG_IDLE;                    // [R4]
                end
                cpg_pkg::CPG_DEAD_HI: if (gcnt_r >= cpg_pkg::CNT_W'(cpg_pkg::DEAD_CYC - 1)) begin
                    gst_r <= cpg_pkg::CPG_OFF;                     // [R3]
                end
                default: gst_r <= cpg_pkg::CPG_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_side_gate_drive_o <= 1'b0;
            low_side_gate_drive_o  <= 1'b0;
        end else begin
            high_side_gate_drive_o <= gst_r == cpg_pkg::CPG_HIGH && hs_allow;          // [R14]
            low_side_gate_drive_o  <= (gst_r == cpg_pkg::CPG_LOW || gst_r == cpg_pkg::CPG_PULSE)
                                      && supply_ok;                                    // [R3] [R4]
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    AST_NO_SHOOT: assert property (@(posedge clk_i) disable iff (!reset_n_i)    // [R3]
        !(high_side_gate_drive_o && low_side_gate_drive_o)) else $error("Both gate drives on.");
    AST_DEAD_GAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)    // [R3]
        $fell(high_side_gate_drive_o) |-> (!low_side_gate_drive_o)[*2]) else $error("No dead time after high side.");
    AST_SEL_EXCL: assert property (@(posedge clk_i) disable iff (!reset_n_i)    // [R19]
        !(adapter_switch_drive_o && battery_switch_drive_o)) else $error("Both switches on.");
    AST_BBM_GAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)     // [R19]
        (sel_r == cpg_pkg::CPG_SEL_BAT) ##1 (sel_r == cpg_pkg::CPG_SEL_GAP) |-> ##1 !adapter_switch_drive_o[*8])
        else $error("Adapter switch on during gap.");
    AST_OVP_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i)     // [R6]
        flag_r[cpg_pkg::F_OVP] |-> ##1 !charge_enable_o && !adapter_switch_drive_o) else $error("Overvoltage not acted.");
    AST_OC_HS: assert property (@(posedge clk_i) disable iff (!reset_n_i)       // [R14]
        oc_r |-> ##1 !high_side_gate_drive_o) else $error("High side on in overcurrent.");
    AST_BOOT_HS: assert property (@(posedge clk_i) disable iff (!reset_n_i)     // [R5]
        flag_r[cpg_pkg::F_BOOT_LOW] |-> ##1 !high_side_gate_drive_o) else $error("High side on with low bootstrap.");
    AST_BOOT_LS: assert property (@(posedge clk_i) disable iff (!reset_n_i)     // [R5]
        flag_r[cpg_pkg::F_BOOT_LOW] |=> gst_r != cpg_pkg::CPG_LOW) else $error("Low side held with low bootstrap.");
    AST_SUPPLY_UNDERVOLTAGE_LOCK: assert property (@(posedge clk_i) disable iff (!reset_n_i)        // [R8]
        !supply_ok |-> ##1 !gate_bias_regulator_en_o && !battery_switch_drive_o && !input_current_monitor_en_o)
        else $error("Bias active at low supply.");
    AST_GOOD_QUAL: assert property (@(posedge clk_i) disable iff (!reset_n_i)   // [R16]
        $rose(adapter_good_out_oe_o) |-> $past(qual_cnt_r) == cpg_pkg::CNT_W'(QUAL_CYCLES - 1))
        else $error("Adapter good early.");
    AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (!reset_n_i)   // [R4]
        $rose(gst_r == cpg_pkg::CPG_PULSE) |-> (gst_r == cpg_pkg::CPG_PULSE)[*3] ##1 gst_r != cpg_pkg::CPG_PULSE)
        else $error("Recharge pulse length wrong.");
    AST_BAT_OV: assert property (@(posedge clk_i) disable iff (!reset_n_i)      // [R10]
        bat_ov_r |-> ##1 !high_side_gate_drive_o) else $error("High side on in battery overvoltage.");
    CV_SYNC: cover property (@(posedge clk_i) disable iff (!reset_n_i) gst_r == cpg_pkg::CPG_LOW);
    CV_PULSE: cover property (@(posedge clk_i) disable iff (!reset_n_i) gst_r == cpg_pkg::CPG_PULSE);
    CV_ADP: cover property (@(posedge clk_i) disable iff (!reset_n_i) adapter_switch_drive_o);
    CV_LEARN_EXIT: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        flag_r[cpg_pkg::F_LEARN] && flag_r[cpg_pkg::F_BATTERY_SHORT_FLAG] && adapter_switch_drive_o);
endmodule // cpg_top

// ---- bench/cpg_partner.sv ----
// Purpose: Far-side model of the adapter-good status pin and its pull-up.
// Assumes: An external pull-up to the host rail.
// Notes:   The pin reads high whenever the open-drain driver lets go.
`timescale 1ns/1ps
module cpg_partner (
    input  wire logic adapter_good_out_oe_i,                       // Driver pulls the pin.
    input  wire logic adapter_good_out_i,                          // Driven level.
    output logic      adapter_good_pin_o                           // Resolved pin level.
);
    // ==========================================================
    // Pin resolution
    assign adapter_good_pin_o = adapter_good_out_oe_i ? adapter_good_out_i : 1'b1;
endmodule // cpg_partner

// ---- bench/cpg_top_bench.sv ----
// Purpose: Self-checking bench for cpg_top.
// Assumes: Qualification count cut to 50 cycles.
// Notes:   Input bits, msb first: pwm slo shi boot ovp sup d06 d24 adpl b104 b102 bsh learn oc hot cool.
`timescale 1ns/1ps
module cpg_top_bench;
    typedef struct packed {logic [15:0] vin; logic [6:0] vout;} cpg_row_t;
    logic        clk_i, reset_n_i, pin;
    logic [15:0] v;
    logic        hs, ls, adp, bat, oe, od, mon, bias, chg, eig, bsf, tsf, ovf, cont;
    int          fails, check_count, ls_cnt, ovl;
    cpg_row_t    rows [12];
    cpg_top #(.QUAL_CYCLES(50)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .pwm_high_i(v[15]),
        .sync_below_13mv_i(v[14]), .sync_above_21mv_i(v[13]), .boot_below_4v_i(v[12]), .ovp_above_i(v[11]),
        .supply_above_5v_i(v[10]), .detect_above_0v6_i(v[9]), .detect_above_2v4_i(v[8]),
        .adapter_node_below_3v_i(v[7]), .bat_above_104_i(v[6]), .bat_below_102_i(v[5]), .battery_short_flag_i(v[4]),
        .learn_i(v[3]), .overcurrent_i(v[2]), .thermal_hot_i(v[1]), .thermal_cool_i(v[0]),
        .high_side_gate_drive_o(hs), .low_side_gate_drive_o(ls), .adapter_switch_drive_o(adp),
        .battery_switch_drive_o(bat), .adapter_good_out_oe_o(oe), .adapter_good_out_o(od),
        .input_current_monitor_en_o(mon), .gate_bias_regulator_en_o(bias), .charge_enable_o(chg),
        .precharge_eighth_o(eig), .battery_short_flag_o(bsf), .thermal_shutdown_flag_o(tsf),
        .input_overvoltage_flag_o(ovf), .continuous_mode_o(cont));
    cpg_partner i_far (.adapter_good_out_oe_i(oe), .adapter_good_out_i(od), .adapter_good_pin_o(pin));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [6:0] a, input logic [6:0] e);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, a, e);
        end
    endtask
    // Overlap of both gate drives is counted in each of the n sampled cycles of every run, but not in the cycle in which the new inputs are applied.
    task automatic run(input logic [15:0] nv, input int n);
        @(posedge clk_i);
        v <= nv;
        ls_cnt = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            ls_cnt += ls;
            ovl += hs & ls;
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and sequence
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (6000) @(posedge clk_i);
        fails++;
        end_of_test();
    end
    initial begin
        rows = '{'{16'h0221, 7'h00}, '{16'h0621, 7'h06}, '{16'h0E21, 7'h46}, '{16'h0621, 7'h06},
                 '{16'h0631, 7'h1E}, '{16'h0622, 7'h26}, '{16'h0620, 7'h26}, '{16'h0621, 7'h06},
                 '{16'h2621, 7'h07}, '{16'h0621, 7'h07}, '{16'h4621, 7'h06}, '{16'h0421, 7'h02}};
        v = 16'h0621;
        reset_n_i = 1'b0;
        fails = 0;
        check_count = 0;
        ovl = 0;
        repeat (20) @(posedge clk_i);
        #1 chk({hs, ls, adp, bat, oe, chg, bias}, 7'h00);
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i].vin, 8);
            chk({ovf, tsf, bsf, eig, mon, bias, cont}, rows[i].vout);
        end
        run(16'h0721, 30);
        chk({6'h00, oe}, 7'h00);
        run(16'h0721, 40);
        chk({5'h00, oe, pin}, 7'h02);
        chk({5'h00, adp, bat}, 7'h00);
        run(16'h2721, 420);
        chk({4'h0, adp, bat, chg}, 7'h05);
        run(16'hA721, 8);
        chk({5'h00, hs, ls}, 7'h02);
        run(16'h2721, 8);
        chk({5'h00, hs, ls}, 7'h01);
        run(16'hC721, 8);
        run(16'h4721, 20);
        chk(ls_cnt[6:0], 7'h03);
        run(16'hD721, 20);
        chk({5'h00, hs, ls}, 7'h00);
        chk(ls_cnt[6:0], 7'h03);
        run(16'hA725, 10);
        chk({6'h00, hs}, 7'h00);
        run(16'hA721, 10);
        chk({6'h00, hs}, 7'h01);
        run(16'hA741, 10);
        chk({6'h00, hs}, 7'h00);
        run(16'hA701, 10);
        chk({6'h00, hs}, 7'h00);
        run(16'hA721, 10);
        chk({6'h00, hs}, 7'h01);
        run(16'h2729, 420);
        chk({4'h0, adp, bat, chg}, 7'h02);
        run(16'h2739, 420);
        chk({4'h0, adp, bat, chg}, 7'h04);
        run(16'h2729, 420);
        chk({4'h0, adp, bat, chg}, 7'h02);
        run(16'h2721, 420);
        run(16'h2F21, 420);
        chk({4'h0, adp, bat, chg}, 7'h02);
        run(16'h27A1, 420);
        chk({4'h0, adp, bat, chg}, 7'h02);
        run(16'h2721, 420);
        chk({4'h0, adp, bat, chg}, 7'h05);
        chk(ovl[6:0], 7'h00);
        end_of_test();
    end
endmodule // cpg_top_bench
